// ---- rtl/spf_pkg.sv ----
// Shared constants and types for the self-programming control link
package spf_pkg;
  // Control byte bit positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_ERASE    = 1;
  localparam int BIT_WRITE    = 2;
  localparam int BIT_LOCK     = 3;
  localparam int BIT_REENABLE = 4;
  localparam int BIT_SIG      = 5;
  localparam int BIT_BUSY     = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] CMD_MASK   = 6'h3F;
  // Command codes in bits 5:0, bit 7 is don't care
  localparam logic [5:0] CMD_ERASE    = 6'h03;
  localparam logic [5:0] CMD_WRITE    = 6'h05;
  localparam logic [5:0] CMD_LOCKWR   = 6'h09;
  localparam logic [5:0] CMD_REENABLE = 6'h11;
  localparam logic [5:0] CMD_FILL     = 6'h01;
  localparam logic [5:0] CMD_LOCKRD   = 6'h09;
  localparam logic [5:0] CMD_SIGNATURE_READ_SELECT    = 6'h21;
  // Pointer values for timed reads
  localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] Z_LOCK      = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] Z_SIG1      = 16'h0000;
  localparam logic [15:0] Z_CALIB     = 16'h0001;
  localparam logic [15:0] Z_SIG2      = 16'h0002;
  localparam logic [15:0] Z_SIG3      = 16'h0004;
  localparam logic [7:0]  RESERVED_RD = 8'hFF;
  // Timed windows, in cycles after the control write
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  // Programming time
  localparam int CLK_PERIOD_NS   = 8;
  localparam int PROG_MIN_NS     = 3700000;
  localparam int PROG_MAX_NS     = 4500000;
  localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int PROG_CNT_W      = 20;
  // Host APB register offsets
  localparam logic [7:0] REG_CTRL_VAL = 8'h00;
  localparam logic [7:0] REG_POINTER  = 8'h04;
  localparam logic [7:0] REG_GO       = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam int GO_START = 0;
  localparam int GO_LOAD  = 1;
  localparam int ST_BUSY  = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_LOAD_LSB = 8;
  localparam int ST_CTRL_LSB = 16;
  typedef enum logic [2:0] {
    SPF_IDLE      = 3'b000,
    SPF_WAIT_PREV = 3'b001,
    SPF_WAIT_EE   = 3'b010,
    SPF_WRITE     = 3'b011,
    SPF_ISSUE     = 3'b100,
    SPF_WAIT_DATA = 3'b101
  } spf_host_state_t;
endpackage

// ---- rtl/spf_link_if.sv ----
// Link between the processor core end and the self-programming controller
`timescale 1ns/1ps
interface spf_link_if;
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic [7:0]  ctrl_rdata;
  logic        store_req;
  logic        load_req;
  logic [15:0] pointer;
  logic [7:0]  load_data;
  logic        load_valid;
  logic        eeprom_write_busy;
  modport core (output ctrl_wr, ctrl_wdata, store_req, load_req, pointer,
                input ctrl_rdata, load_data, load_valid, eeprom_write_busy);
  modport dev (input ctrl_wr, ctrl_wdata, store_req, load_req, pointer,
               output ctrl_rdata, load_data, load_valid, eeprom_write_busy);
endinterface

// ---- rtl/spf_device.sv ----
// Self-programming controller: timed windows, fuse/lock/signature reads, write timing
// Notes on behaviour
// RL1: EEPROM write busy refuses programming commands
// RL2: EEPROM write busy refuses fuse/lock reads
// RL3: Software polls EEPROM busy before control write
// RL4: Pointer 1 plus lock select reads lock
// RL5: Lock select clears on read or timeout
// RL6: Bits clear means ordinary flash read
// RL7: Pointer 0 plus lock select reads low fuse
// RL8: Pointer 3 plus lock select reads high fuse
// RL9: Pointer 2 plus lock select reads extended fuse
// RL10: Programmed bits read zero, unprogrammed one
// RL11: Signature select reads addressed signature byte
// RL12: Signature select clears on read or timeout
// RL13: Signature bytes at 0,2,4, calibration at 1
// RL14: Flash write survives system reset
// RL15: Flash write lasts 3.7 to 4.5 ms
// RL16: Software waits for enable clear first
// RL17: Software keeps timed sequence uninterrupted
// RL18: Software re-enables until busy flag clears
// RL19: Store within four cycles starts command
// RL20: Busy flag held until re-enable written
// RL21: Fuse values latched at reset, eight bits
`timescale 1ns/1ps
module spf_device
  import spf_pkg::*;
#(
  parameter int          PROG_CYCLES = spf_pkg::PROG_MIN_CYCLES,
  parameter logic [7:0]  SIG_BYTE1   = 8'hA5, // Arbitrary identity value
  parameter logic [7:0]  SIG_BYTE2   = 8'h5A, // Arbitrary identity value
  parameter logic [7:0]  SIG_BYTE3   = 8'h3C  // Arbitrary identity value
)(
  // Clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        sys_reset_n,
  // Core link
  spf_link_if.dev          link,
  // EEPROM status
  input  wire logic        eeprom_write_busy,
  // Nonvolatile cells, 1 = programmed
  input  wire logic [7:0]  fuse_low_prog,
  input  wire logic [7:0]  fuse_high_prog,
  input  wire logic [7:0]  fuse_ext_prog,
  input  wire logic [7:0]  lock_prog,
  input  wire logic [7:0]  calib_byte,
  // Flash array
  output logic [15:0]      flash_raddr,
  input  wire logic [7:0]  flash_rdata,
  output logic             flash_erase,
  output logic             flash_write,
  output logic             flash_lock_write,
  output logic             flash_buffer_fill,
  output logic             flash_busy
);
  import spf_pkg::*;

  // Refused at elaboration: the counter and the timing range cannot serve it
  if (PROG_CYCLES < PROG_MIN_CYCLES || PROG_CYCLES > PROG_MAX_CYCLES
      || PROG_CYCLES >= (1 << PROG_CNT_W))
  begin : g_prog_cycles_check
    $error("PROG_CYCLES outside the programming time range");
  end

  localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES - 1);

  typedef struct packed {
    logic [5:0]            cmd;
    logic                  rww_busy;
    logic [2:0]            win;
    logic                  prog_active;
    logic [PROG_CNT_W-1:0] prog_cnt;
    logic                  load_valid;
    logic [7:0]            load_data;
    logic                  captured;
    logic [7:0]            fuse_low;
    logic [7:0]            fuse_high;
    logic [7:0]            fuse_ext;
    logic [7:0]            lock;
    logic [7:0]            calib;
    logic                  erase;
    logic                  write;
    logic                  lock_wr;
    logic                  fill;
  } spf_dev_state_t;

  spf_dev_state_t st;
  spf_dev_state_t next_st;

  function automatic logic [7:0] fuse_read(input logic [15:0] z, input spf_dev_state_t s);
    case (z)
      Z_FUSE_LOW:  fuse_read = s.fuse_low;   // [RL7]
      Z_LOCK:      fuse_read = s.lock;       // [RL4]
      Z_FUSE_EXT:  fuse_read = s.fuse_ext;   // [RL9]
      Z_FUSE_HIGH: fuse_read = s.fuse_high;  // [RL8]
      default:     fuse_read = RESERVED_RD;
    endcase
  endfunction

  function automatic logic [7:0] sig_read(input logic [15:0] z, input logic [7:0] cal);
    case (z)
      Z_SIG1:  sig_read = SIG_BYTE1;         // [RL13]
      Z_CALIB: sig_read = cal;
      Z_SIG2:  sig_read = SIG_BYTE2;
      Z_SIG3:  sig_read = SIG_BYTE3;
      default: sig_read = RESERVED_RD;
    endcase
  endfunction

  logic enable_on;
  logic lock_sel;
  logic sig_sel;
  logic load_in_window;
  logic store_in_window;

  assign enable_on       = st.cmd[BIT_ENABLE];
  assign lock_sel        = enable_on && st.cmd[BIT_LOCK];
  assign sig_sel         = enable_on && st.cmd[BIT_SIG];
  assign load_in_window  = st.win != 3'h0 && st.win <= LOAD_WINDOW;
  assign store_in_window = st.win != 3'h0 && st.win <= STORE_WINDOW;

  always_comb
  begin
    next_st            = st;
    next_st.load_valid = 1'b0;
    next_st.erase      = 1'b0;
    next_st.write      = 1'b0;
    next_st.lock_wr    = 1'b0;
    next_st.fill       = 1'b0;
    // Window counter runs while a command waits for its instruction
    if (st.win != 3'h0 && !st.prog_active)
      next_st.win = st.win + 3'h1;
    // Timed write of the control byte
    if (link.ctrl_wr && !st.prog_active && !eeprom_write_busy)  // [RL1] [RL2]
    begin
      next_st.cmd = link.ctrl_wdata[5:0] & CMD_MASK;
      next_st.win = link.ctrl_wdata[BIT_ENABLE] ? 3'h1 : 3'h0;
    end
    // Loads: timed read or plain flash read
    if (link.load_req)
    begin
      next_st.load_valid = 1'b1;
      if (sig_sel && load_in_window)
      begin
        next_st.load_data = sig_read(link.pointer, st.calib);  // [RL11]
        next_st.cmd       = 6'h00;                             // [RL12]
        next_st.win       = 3'h0;
      end
      else if (lock_sel && load_in_window)
      begin
        next_st.load_data = fuse_read(link.pointer, st);       // [RL4]
        next_st.cmd       = 6'h00;                             // [RL5]
        next_st.win       = 3'h0;
      end
      else
        next_st.load_data = flash_rdata;                       // [RL6]
    end
    // Store inside the window starts the command
    if (link.store_req && enable_on && store_in_window && !st.prog_active)  // [RL19]
    begin
      next_st.win = 3'h0;
      case (st.cmd)
        CMD_ERASE:
        begin
          next_st.erase       = 1'b1;
          next_st.prog_active = 1'b1;
          next_st.rww_busy    = 1'b1;   // [RL20]
          next_st.prog_cnt    = '0;
        end
        CMD_WRITE:
        begin
          next_st.write       = 1'b1;
          next_st.prog_active = 1'b1;
          next_st.rww_busy    = 1'b1;   // [RL20]
          next_st.prog_cnt    = '0;
        end
        CMD_LOCKWR:
        begin
          next_st.lock_wr     = 1'b1;
          next_st.prog_active = 1'b1;
          next_st.prog_cnt    = '0;
        end
        CMD_REENABLE:
        begin
          next_st.rww_busy = 1'b0;      // [RL20]
          next_st.cmd      = 6'h00;
        end
        CMD_FILL:
        begin
          next_st.fill = 1'b1;
          next_st.cmd  = 6'h00;
        end
        default:
          next_st.cmd = 6'h00;
      endcase
    end
    // Missed windows drop the request
    else if (enable_on && !st.prog_active
             && st.win == (st.cmd[BIT_SIG] ? LOAD_WINDOW : STORE_WINDOW))  // [RL5] [RL12]
    begin
      next_st.cmd = 6'h00;
      next_st.win = 3'h0;
    end
    // Oscillator-timed programming
    if (st.prog_active)
    begin
      if (st.prog_cnt == PROG_LAST)      // [RL15]
      begin
        next_st.prog_active = 1'b0;
        next_st.cmd         = 6'h00;
      end
      else
        next_st.prog_cnt = st.prog_cnt + PROG_CNT_W'(1);
    end
    // System reset clears requests but lets a running write finish
    if (!sys_reset_n || !st.captured)
    begin
      if (!st.prog_active)               // [RL14]
        next_st.cmd = 6'h00;
      next_st.win       = 3'h0;
      next_st.captured  = 1'b1;
      next_st.fuse_low  = ~fuse_low_prog;   // [RL10] [RL21]
      next_st.fuse_high = ~fuse_high_prog;
      next_st.fuse_ext  = ~fuse_ext_prog;
      next_st.lock      = ~lock_prog;
      next_st.calib     = calib_byte;
    end
  end

  // Power-loss reset only; system reset is handled above
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  always_comb
  begin
    link.ctrl_rdata           = {1'b0, st.rww_busy, st.cmd};
    link.ctrl_rdata[BIT_BUSY] = st.rww_busy;
  end

  assign link.load_data         = st.load_data;
  assign link.load_valid        = st.load_valid;
  assign link.eeprom_write_busy = eeprom_write_busy;
  assign flash_raddr            = link.pointer;
  assign flash_erase            = st.erase;
  assign flash_write            = st.write;
  assign flash_lock_write       = st.lock_wr;
  assign flash_buffer_fill      = st.fill;
  assign flash_busy             = st.prog_active;
endmodule

// ---- rtl/spf_core.sv ----
// Core end: APB-driven issuer of timed control writes, stores and loads
`timescale 1ns/1ps
module spf_core
  import spf_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Device link
  spf_link_if.core         link
);
  import spf_pkg::*;

  typedef struct packed {
    spf_host_state_t state;
    logic [7:0]      ctrl_val;
    logic [15:0]     pointer;
    logic            is_load;
    logic            refused;
    logic [7:0]      load_byte;
    logic [31:0]     rdata;
    logic            ctrl_wr;
    logic            store_req;
    logic            load_req;
  } spf_core_state_t;

  spf_core_state_t st;
  spf_core_state_t next_st;
  logic            access;
  logic            mapped;

  assign access = psel && penable;
  assign mapped = paddr == REG_CTRL_VAL || paddr == REG_POINTER
                  || paddr == REG_GO || paddr == REG_STATUS;

  always_comb
  begin
    next_st           = st;
    next_st.ctrl_wr   = 1'b0;
    next_st.store_req = 1'b0;
    next_st.load_req  = 1'b0;
    if (access && pwrite && st.state == SPF_IDLE)
    begin
      case (paddr)
        REG_CTRL_VAL: next_st.ctrl_val = pwdata[7:0];
        REG_POINTER:  next_st.pointer  = pwdata[15:0];
        REG_GO:
          if (pwdata[GO_START])
          begin
            next_st.is_load = pwdata[GO_LOAD];
            next_st.refused = 1'b0;
            // Plain reads of the blocked section are refused until re-enable
            if (pwdata[GO_LOAD] && st.ctrl_val[5:0] == 6'h00
                && link.ctrl_rdata[BIT_BUSY])  // [RL18]
              next_st.refused = 1'b1;
            else
              next_st.state = SPF_WAIT_PREV;
          end
        default: ;
      endcase
    end
    case (st.state)
      SPF_IDLE: ;
      SPF_WAIT_PREV:
        if (!link.ctrl_rdata[BIT_ENABLE])   // [RL16]
          next_st.state = SPF_WAIT_EE;
      SPF_WAIT_EE:
        if (!link.eeprom_write_busy)        // [RL3]
        begin
          next_st.state   = SPF_WRITE;
          next_st.ctrl_wr = 1'b1;
        end
      SPF_WRITE:
      begin
        // Nothing may come between write and instruction
        next_st.state = SPF_ISSUE;          // [RL17]
        if (st.is_load)
          next_st.load_req = 1'b1;          // [RL4] [RL11]
        else
          next_st.store_req = 1'b1;         // [RL19]
      end
      SPF_ISSUE:
        next_st.state = st.is_load ? SPF_WAIT_DATA : SPF_IDLE;
      SPF_WAIT_DATA:
        if (link.load_valid)
        begin
          next_st.load_byte = link.load_data;
          next_st.state     = SPF_IDLE;
        end
      default:
        next_st.state = SPF_IDLE;
    endcase
    next_st.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
      case (paddr)
        REG_CTRL_VAL: next_st.rdata = {24'h00_0000, st.ctrl_val};
        REG_POINTER:  next_st.rdata = {16'h0000, st.pointer};
        REG_STATUS:
        begin
          next_st.rdata[ST_BUSY]                   = st.state != SPF_IDLE;
          next_st.rdata[ST_REFUSED]                = st.refused;
          next_st.rdata[ST_LOAD_LSB +: 8]          = st.load_byte;
          next_st.rdata[ST_CTRL_LSB +: 8]          = link.ctrl_rdata;
        end
        default: ;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{state: SPF_IDLE, default: '0};
    else
      st <= next_st;
  end

  assign pready          = 1'b1;
  assign pslverr         = access && !mapped;
  assign prdata          = st.rdata;
  assign link.ctrl_wr    = st.ctrl_wr;
  assign link.ctrl_wdata = st.ctrl_val;
  assign link.store_req  = st.store_req;
  assign link.load_req   = st.load_req;
  assign link.pointer    = st.pointer;
endmodule

// ---- dv/spf_link_properties.sv ----
// Checker for timing relations on the core-to-device link
`timescale 1ns/1ps
module spf_link_properties
  import spf_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Link signals
  input wire logic        ctrl_wr,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic [7:0]  ctrl_rdata,
  input wire logic        store_req,
  input wire logic        load_req,
  input wire logic [15:0] pointer,
  input wire logic [7:0]  load_data,
  input wire logic        load_valid,
  input wire logic        eeprom_write_busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence sel_load_s;
    ctrl_wr ##1 (load_req && (ctrl_rdata[BIT_LOCK] || ctrl_rdata[BIT_SIG]));
  endsequence
  sequence erase_go_s;
    ctrl_wr ##1 (store_req && ctrl_rdata[5:0] == CMD_ERASE);
  endsequence
  sequence sig_gap_s;
    ctrl_wr ##1 (load_req && ctrl_rdata[BIT_SIG] && (pointer == 16'h0003 || pointer == 16'h0005));
  endsequence
  AST_LOAD_ANSWER: assert property (load_req |=> load_valid)
    else $error("load without answer");
  AST_VALID_CAUSE: assert property (load_valid |-> $past(load_req))
    else $error("answer without load");
  AST_READ_CLEARS: assert property (sel_load_s |=> load_valid && ctrl_rdata[5:0] == '0)
    else $error("select bits kept after read");
  AST_EE_BLOCK: assert property (ctrl_wr && eeprom_write_busy && ctrl_rdata[5:0] == '0 |=> ctrl_rdata[5:0] == '0)
    else $error("control byte taken during eeprom write");
  AST_CMD_SHOWN: assert property (ctrl_wr && !eeprom_write_busy && ctrl_rdata == '0 |=> ctrl_rdata[5:0] == $past(ctrl_wdata[5:0]))
    else $error("control byte not taken");
  AST_ERASE_START: assert property (erase_go_s |=> ctrl_rdata[BIT_BUSY] && ctrl_rdata[BIT_ENABLE])
    else $error("erase did not start");
  AST_BUSY_CAUSE: assert property ($rose(ctrl_rdata[BIT_BUSY]) |-> $past(store_req))
    else $error("busy flag rose without store");
  AST_ERASE_HOLD: assert property (erase_go_s |=> ctrl_rdata[BIT_ENABLE] [*8])
    else $error("erase ended early");
  AST_SIG_RESERVED: assert property (sig_gap_s |=> load_data == RESERVED_RD)
    else $error("reserved signature place not blank");
  AST_INSTR_FOLLOWS: assert property (ctrl_wr |=> load_req || store_req)
    else $error("instruction did not follow control write");
endmodule

// ---- dv/self_program_fuse_signature_read_test.sv ----
// Testbench joining core and device ends over the link
`timescale 1ns/1ps
module self_program_fuse_signature_read_test;
  import spf_pkg::*;
  localparam logic [7:0] SIG1 = 8'h6E; // Arbitrary identity value
  localparam logic [7:0] SIG2 = 8'h91; // Arbitrary identity value
  localparam logic [7:0] SIG3 = 8'h27; // Arbitrary identity value
  logic        pclk, presetn, sys_reset_n, eeprom_write_busy;
  logic        psel, penable, pwrite, pready, pslverr, err, flash_erase, flash_busy;
  logic        flash_write, flash_lock_write, flash_buffer_fill;
  logic [7:0]  paddr, fl, fh, fe, lk, cal, flash_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] flash_raddr;
  logic [7:0]  cap [5];
  int          fails, n_checks, erases, writes, lock_writes, fills;
  spf_link_if spf_link_if_i ();
  spf_core spf_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(spf_link_if_i.core));
  spf_device #(.SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .SIG_BYTE3(SIG3)) spf_device_i (.pclk(pclk), .presetn(presetn),
    .sys_reset_n(sys_reset_n), .link(spf_link_if_i.dev), .eeprom_write_busy(eeprom_write_busy),
    .fuse_low_prog(fl), .fuse_high_prog(fh), .fuse_ext_prog(fe), .lock_prog(lk), .calib_byte(cal),
    .flash_raddr(flash_raddr), .flash_rdata(flash_rdata), .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_lock_write(flash_lock_write), .flash_buffer_fill(flash_buffer_fill), .flash_busy(flash_busy));
  spf_link_properties spf_link_properties_i (.pclk(pclk), .presetn(presetn), .ctrl_wr(spf_link_if_i.ctrl_wr),
    .ctrl_wdata(spf_link_if_i.ctrl_wdata), .ctrl_rdata(spf_link_if_i.ctrl_rdata), .store_req(spf_link_if_i.store_req),
    .load_req(spf_link_if_i.load_req), .pointer(spf_link_if_i.pointer), .load_data(spf_link_if_i.load_data),
    .load_valid(spf_link_if_i.load_valid), .eeprom_write_busy(spf_link_if_i.eeprom_write_busy));
  // Flash array contents as a function of address
  assign flash_rdata = flash_raddr[7:0] ^ flash_raddr[15:8] ^ 8'h5A;
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Counts every command pulse the device launches
  always @(posedge pclk)
  begin
    erases      <= erases + int'(flash_erase === 1'b1);
    writes      <= writes + int'(flash_write === 1'b1);
    lock_writes <= lock_writes + int'(flash_lock_write === 1'b1);
    fills       <= fills + int'(flash_buffer_fill === 1'b1);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fails++;
      end_sim();
    end
  endtask
  task automatic run_cmd(input logic [7:0] c, input logic [15:0] p, input logic ld);
    apb(1'b1, REG_CTRL_VAL, {24'h0, c});
    apb(1'b1, REG_POINTER, {16'h0, p});
    apb(1'b1, REG_GO, {30'h0, ld, 1'b1});
  endtask
  // Polls the core, bounded so a stuck sequence ends the run
  task automatic wait_idle();
    for (int k = 0; k < 40 && rd[ST_BUSY] !== 1'b0; k++)
      apb(1'b0, REG_STATUS, 32'h0);
    if (rd[ST_BUSY] !== 1'b0)
    begin
      fails++;
      end_sim();
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] c, input logic [15:0] p);
    if (c[BIT_LOCK])
      return (p < 16'h0004) ? cap[p[1:0]] : 8'hFF;
    if (c[BIT_SIG])
      case (p)
        16'h0000: return SIG1;
        16'h0001: return cap[4];
        16'h0002: return SIG2;
        16'h0004: return SIG3;
        default:  return 8'hFF;
      endcase
    return p[7:0] ^ p[15:8] ^ 8'h5A;
  endfunction
  task automatic read_chk(input logic [7:0] c, input logic [15:0] p, input logic [7:0] x);
    run_cmd(c, p, 1'b1);
    rd = 32'h1;
    wait_idle();
    check("load byte", 32'(rd[15:8]), 32'(exp_rd(x, p)));
    check("control after read", 32'(rd[23:16]), 32'h0);
  endtask
  // Fuses are captured inverted at release, then the cells change under them
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cap = '{~fl, ~lk, ~fe, ~fh, cal};
    repeat (2) @(posedge pclk);
    {fl, fh, fe, lk, cal} <= 40'({$urandom(), $urandom()});
  endtask
  initial
  begin
    void'($urandom(32'h81EE));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, sys_reset_n, eeprom_write_busy} = 3'b010;
    {fl, fh, fe, lk, cal} = 40'({$urandom(), $urandom()});
    {fails, n_checks} = '0;
    do_reset();
    apb(1'b0, REG_STATUS, 32'h0);
    check("status after reset", rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    for (int i = 0; i < 6; i++)
      read_chk({2'b00, CMD_LOCKRD}, 16'(i), {2'b00, CMD_LOCKRD});
    for (int i = 0; i < 6; i++)
      read_chk({2'b00, CMD_SIGNATURE_READ_SELECT}, 16'(i), {2'b00, CMD_SIGNATURE_READ_SELECT});
    for (int i = 0; i < 4; i++)
      read_chk(8'h00, 16'($urandom()), 8'h00);
    // EEPROM write starts just as the control byte reaches the device
    run_cmd({2'b00, CMD_LOCKRD}, 16'h0001, 1'b1);
    repeat (2) @(posedge pclk);
    eeprom_write_busy <= 1'b1;
    rd = 32'h1;
    wait_idle();
    check("load during eeprom write", 32'(rd[15:8]), 32'(exp_rd(8'h00, 16'h0001)));
    run_cmd({2'b00, CMD_LOCKRD}, 16'h0003, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    check("core held by eeprom", 32'(rd[ST_BUSY]), 32'h1);
    eeprom_write_busy <= 1'b0;
    wait_idle();
    check("lock read after eeprom", 32'(rd[15:8]), 32'(cap[3]));
    run_cmd({2'b00, CMD_FILL}, 16'h0100, 1'b0);
    rd = 32'h1;
    wait_idle();
    check("fill pulses", 32'(fills), 32'h1);
    check("control after fill", 32'(rd[23:16]), 32'h0);
    run_cmd({2'b00, CMD_ERASE}, 16'h0100, 1'b0);
    rd = 32'h1;
    wait_idle();
    check("erase pulses", 32'(erases), 32'h1);
    check("control during erase", 32'(rd[23:16]), {24'h0, 2'b01, CMD_ERASE});
    // Plain load while the section is blocked must be held back
    run_cmd(8'h00, 16'h0010, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    check("plain load refused", 32'(rd[1:0]), 32'h2);
    run_cmd({2'b00, CMD_LOCKRD}, 16'h0001, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    check("core held by enable", 32'(rd[ST_BUSY]), 32'h1);
    sys_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    sys_reset_n <= 1'b1;
    repeat (50000) @(posedge pclk);
    check("write survives reset", 32'(flash_busy), 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    check("busy survives reset", 32'(rd[23:16]), {24'h0, 2'b01, CMD_ERASE});
    do_reset();
    read_chk({2'b00, CMD_LOCKRD}, 16'h0002, {2'b00, CMD_LOCKRD});
    run_cmd({2'b00, CMD_WRITE}, 16'h0200, 1'b0);
    rd = 32'h1;
    wait_idle();
    check("write pulses", 32'(writes), 32'h1);
    check("control during write", 32'(rd[23:16]), {24'h0, 2'b01, CMD_WRITE});
    do_reset();
    run_cmd({2'b00, CMD_LOCKWR}, 16'h0001, 1'b0);
    rd = 32'h1;
    wait_idle();
    check("lock write pulses", 32'(lock_writes), 32'h1);
    check("control during lock write", 32'(rd[23:16]), {26'h0, CMD_LOCKWR});
    end_sim();
  end
endmodule
